// ==== src/rst_seq.sv ====
// reset sequencer: power-up delay, brown-out, external pin, watchdog
// assumes lfosc_tick is a one-cycle pulse per watchdog oscillator period
//
// Operation
// - 72 ms delay only after power-on or brown-out
// - chip held in reset while delay counts
// - delay timer counts watchdog oscillator ticks
// - delay disable bit set skips the delay
// - watchdog counts 31 kHz oscillator ticks
// - shared 8-bit prescaler, 17 ms to 2.2 s
// - watchdog runs while its enable is set, in run or sleep only
// - assign bit and rate field pick period
// - watchdog cleared: disabled, clear instruction, wake
// - brown-out field 11 on, 10 awake, 0x off
// - qualified low supply forces reset while brown-out detection is on
// - brown-out during delay restarts 64 ms delay
// - delay starts after power-on pulse ends
// - pin low past time-out releases immediately
// - brown-out flag cleared by brown-out reset
// - power-on flag zero on power-on only
// - status bits encode each reset cause
// - power-on or brown-out loads status 0001 1xxx
// - pin enable bit makes pin active-low reset
`timescale 1ns/1ps
`default_nettype none
module rst_seq (
  // clock, reset, enable
  input wire logic clock,
  input wire logic rstn,
  input wire logic ce,
  // axi4-lite write
  input wire logic [13:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // axi4-lite read
  input wire logic [13:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // oscillator, supply and pin
  input wire logic lfosc_tick,
  input wire logic brownout_low,
  input wire logic ext_reset_pin_n,
  // core events
  input wire logic sleep_instr,
  input wire logic watchdog_clear_instr,
  input wire logic irq_wake,
  // sequencer outputs
  output logic chip_reset,
  output logic sleeping,
  output logic wake_resume
);

  rst_seq_pkg::seq_state_t state_ff;
  rst_seq_pkg::seq_state_t nxt_state;
  rst_seq_pkg::cfg_t cfg_ff;
  logic [7:0] status_ff;
  logic [7:0] option_ff;
  logic [1:0] reset_cause_flags_ff;
  logic [11:0] powerup_delay_timer_cnt_ff;
  logic short_delay_ff;
  logic [7:0] bor_cnt_ff;
  logic external_reset_pin_low_q_ff;
  logic [9:0] base_cnt_ff;
  logic [7:0] pre_cnt_ff;
  logic chip_reset_ff;
  logic sleeping_ff;
  logic wake_resume_ff;
  logic awready_ff;
  logic wready_ff;
  logic bvalid_ff;
  logic [1:0] bresp_ff;
  logic arready_ff;
  logic rvalid_ff;
  logic [31:0] rdata_ff;
  logic [1:0] rresp_ff;
  logic aw_got_ff;
  logic w_got_ff;
  logic [13:0] waddr_ff;
  logic [31:0] wdata_ff;
  logic [3:0] wstrb_ff;

  logic awake;
  logic bor_en;
  logic bor_low;
  logic bor_hold;
  logic bor_trip;
  logic external_reset_pin_low;
  logic external_reset_pin_fall;
  logic [11:0] powerup_delay_timer_last;
  logic powerup_delay_timer_done;
  logic [7:0] pre_last;
  logic wdt_clear;
  logic wdt_expire;
  logic wdt_reset;
  logic wdt_wake;
  logic any_wake;
  logic wr_fire;
  logic [2:0] wsel;

  // address decode shared by both channels
  function automatic logic [2:0] reg_sel(input logic [13:0] a);
    if (a == rst_seq_pkg::STATUS_ADDR) begin
      reg_sel = 3'h1;
    end else if (a == rst_seq_pkg::OPTION_ADDR) begin
      reg_sel = 3'h2;
    end else if (a == rst_seq_pkg::RESET_CAUSE_FLAGS_ADDR) begin
      reg_sel = 3'h3;
    end else if (a == rst_seq_pkg::CFG_ADDR) begin
      reg_sel = 3'h4;
    end else begin
      reg_sel = 3'h0;
    end
  endfunction : reg_sel

  assign awake = (state_ff == rst_seq_pkg::ST_RUN) || (state_ff == rst_seq_pkg::ST_SLEEP);
  // brown-out detection off during sleep for the 10 setting
  assign bor_en = cfg_ff.brownout_enable_field[1] && (cfg_ff.brownout_enable_field[0] || state_ff != rst_seq_pkg::ST_SLEEP);
  assign bor_low = bor_en && brownout_low;
  assign bor_hold = bor_low && (bor_cnt_ff == rst_seq_pkg::BOR_QUALIFY_CYC);
  assign bor_trip = bor_low && (bor_cnt_ff == rst_seq_pkg::BOR_QUALIFY_CYC - 8'h01);
  assign external_reset_pin_low = cfg_ff.external_reset_pin_enable && !ext_reset_pin_n;
  assign external_reset_pin_fall = external_reset_pin_low && !external_reset_pin_low_q_ff && awake;
  assign powerup_delay_timer_last = short_delay_ff ? rst_seq_pkg::POWERUP_DELAY_TIMER_SHORT_TICKS - 12'h001
                                    : rst_seq_pkg::POWERUP_DELAY_TIMER_LONG_TICKS - 12'h001;
  assign powerup_delay_timer_done = lfosc_tick && (powerup_delay_timer_cnt_ff == powerup_delay_timer_last) && !bor_hold;
  // without assignment the prescaler belongs to the timer, so ratio 1
  assign pre_last = option_ff[rst_seq_pkg::PSA_BIT] ? 8'((9'h001 << option_ff[2:0]) - 9'h001) : 8'h00;
  assign wdt_clear = !cfg_ff.wdt_en || watchdog_clear_instr || any_wake || !awake;
  assign wdt_expire = cfg_ff.wdt_en && awake && !watchdog_clear_instr && lfosc_tick
                      && (base_cnt_ff == rst_seq_pkg::WDT_BASE_TICKS - 10'h001)
                      && (pre_cnt_ff == pre_last);
  assign wdt_reset = wdt_expire && (state_ff == rst_seq_pkg::ST_RUN);
  assign wdt_wake = wdt_expire && (state_ff == rst_seq_pkg::ST_SLEEP);
  assign any_wake = (state_ff == rst_seq_pkg::ST_SLEEP) && (wdt_expire || irq_wake || external_reset_pin_fall);
  assign wr_fire = aw_got_ff && w_got_ff && !bvalid_ff;
  assign wsel = reg_sel(waddr_ff);

  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      rst_seq_pkg::ST_POWERON: begin
        if (!bor_hold) begin
          nxt_state = cfg_ff.powerup_delay_timer_disable ? rst_seq_pkg::ST_RUN : rst_seq_pkg::ST_DELAY;
        end
      end
      rst_seq_pkg::ST_DELAY: begin
        if (powerup_delay_timer_done) begin
          nxt_state = rst_seq_pkg::ST_RUN;
        end
      end
      rst_seq_pkg::ST_RUN: begin
        if (sleep_instr && !wdt_reset && !external_reset_pin_low) begin
          nxt_state = rst_seq_pkg::ST_SLEEP;
        end
      end
      rst_seq_pkg::ST_SLEEP: begin
        if (any_wake) begin
          nxt_state = rst_seq_pkg::ST_RUN;
        end
      end
      default: begin
        nxt_state = rst_seq_pkg::ST_POWERON;
      end
    endcase
    if (bor_trip) begin
      nxt_state = rst_seq_pkg::ST_POWERON;
    end
  end

  // sequencer state; the delay begins only once rstn has released
  always_ff @(posedge clock) begin
    if (!rstn) begin
      state_ff <= rst_seq_pkg::ST_POWERON;
    end else if (ce) begin
      state_ff <= nxt_state;
    end
  end

  // brown-out qualify counter
  always_ff @(posedge clock) begin
    if (!rstn) begin
      bor_cnt_ff <= 8'h00;
    end else if (ce) begin
      if (!bor_low) begin
        bor_cnt_ff <= 8'h00;
      end else if (!bor_hold) begin
        bor_cnt_ff <= bor_cnt_ff + 8'h01;
      end
    end
  end

  // power-up delay counts oscillator ticks, not system clocks
  always_ff @(posedge clock) begin
    if (!rstn) begin
      powerup_delay_timer_cnt_ff <= 12'h000;
      short_delay_ff <= 1'b0;
    end else if (ce) begin
      if (bor_trip) begin
        short_delay_ff <= (state_ff == rst_seq_pkg::ST_DELAY);
      end
      if (state_ff != rst_seq_pkg::ST_DELAY || bor_hold) begin
        powerup_delay_timer_cnt_ff <= 12'h000;
      end else if (lfosc_tick && !powerup_delay_timer_done) begin
        powerup_delay_timer_cnt_ff <= powerup_delay_timer_cnt_ff + 12'h001;
      end
    end
  end

  // watchdog: base divider of 17 ms then shared prescaler
  always_ff @(posedge clock) begin
    if (!rstn) begin
      base_cnt_ff <= 10'h000;
      pre_cnt_ff <= 8'h00;
    end else if (ce) begin
      if (wdt_clear) begin
        base_cnt_ff <= 10'h000;
        pre_cnt_ff <= 8'h00;
      end else if (lfosc_tick) begin
        if (base_cnt_ff == rst_seq_pkg::WDT_BASE_TICKS - 10'h001) begin
          base_cnt_ff <= 10'h000;
          pre_cnt_ff <= (pre_cnt_ff == pre_last) ? 8'h00 : pre_cnt_ff + 8'h01;
        end else begin
          base_cnt_ff <= base_cnt_ff + 10'h001;
        end
      end
    end
  end

  // chip reset follows the sequencer, the pin and a watchdog reset; pin acts at once after time-out
  always_ff @(posedge clock) begin
    if (!rstn) begin
      chip_reset_ff <= 1'b1;
      sleeping_ff <= 1'b0;
      wake_resume_ff <= 1'b0;
      external_reset_pin_low_q_ff <= 1'b0;
    end else if (ce) begin
      chip_reset_ff <= (nxt_state == rst_seq_pkg::ST_POWERON) || (nxt_state == rst_seq_pkg::ST_DELAY)
                       || external_reset_pin_low || wdt_reset;
      sleeping_ff <= (nxt_state == rst_seq_pkg::ST_SLEEP);
      wake_resume_ff <= (wdt_wake || irq_wake) && (state_ff == rst_seq_pkg::ST_SLEEP)
                        && !external_reset_pin_low && !bor_trip;
      external_reset_pin_low_q_ff <= external_reset_pin_low;
    end
  end

  // core status: hardware events override a bus write in the same cycle
  always_ff @(posedge clock) begin
    if (!rstn) begin
      status_ff <= rst_seq_pkg::STATUS_RST;
    end else if (ce) begin
      if (wr_fire && wsel == 3'h1 && wstrb_ff[0]) begin
        status_ff <= {wdata_ff[7:5], status_ff[4:3], wdata_ff[2:0]};
      end
      if (bor_trip) begin
        status_ff <= rst_seq_pkg::STATUS_RST;
      end else if (wdt_reset) begin
        status_ff <= {3'h0, 1'b0, status_ff[3:0]};
      end else if (wdt_wake) begin
        status_ff <= {status_ff[7:5], 2'h0, status_ff[2:0]};
      end else if (external_reset_pin_fall && state_ff == rst_seq_pkg::ST_SLEEP) begin
        status_ff <= {3'h0, 2'h2, status_ff[2:0]};
      end else if (external_reset_pin_fall) begin
        status_ff <= {3'h0, status_ff[4:0]};
      end else if (sleep_instr && state_ff == rst_seq_pkg::ST_RUN) begin
        status_ff <= {status_ff[7:5], 2'h2, status_ff[2:0]};
      end else if (watchdog_clear_instr && awake) begin
        status_ff <= {status_ff[7:5], 2'h3, status_ff[2:0]};
      end
    end
  end

  // option reloads on every reset, untouched by wake-up
  always_ff @(posedge clock) begin
    if (!rstn) begin
      option_ff <= rst_seq_pkg::OPTION_RST;
    end else if (ce) begin
      if (bor_trip || wdt_reset || external_reset_pin_fall) begin
        option_ff <= rst_seq_pkg::OPTION_RST;
      end else if (wr_fire && wsel == 3'h2 && wstrb_ff[0]) begin
        option_ff <= wdata_ff[7:0];
      end
    end
  end

  // reset-cause flags; software sets them, rstn clears both, a brown-out clears only the brown-out flag
  always_ff @(posedge clock) begin
    if (!rstn) begin
      reset_cause_flags_ff <= rst_seq_pkg::RESET_CAUSE_FLAGS_RST;
    end else if (ce) begin
      if (wr_fire && wsel == 3'h3 && wstrb_ff[0]) begin
        reset_cause_flags_ff <= wdata_ff[1:0];
      end
      if (bor_trip) begin
        reset_cause_flags_ff[rst_seq_pkg::BOR_BIT] <= 1'b0;
      end
    end
  end

  // configuration word bits, writable for this model
  always_ff @(posedge clock) begin
    if (!rstn) begin
      cfg_ff <= rst_seq_pkg::CFG_RST;
    end else if (ce) begin
      if (wr_fire && wsel == 3'h4 && wstrb_ff[0]) begin
        cfg_ff <= wdata_ff[4:0];
      end
    end
  end

  // write channels are taken independently, answered once both are in
  always_ff @(posedge clock) begin
    if (!rstn) begin
      awready_ff <= 1'b1;
      wready_ff <= 1'b1;
      aw_got_ff <= 1'b0;
      w_got_ff <= 1'b0;
      bvalid_ff <= 1'b0;
      bresp_ff <= rst_seq_pkg::RESP_OKAY;
      waddr_ff <= 14'h0000;
      wdata_ff <= 32'h00000000;
      wstrb_ff <= 4'h0;
    end else if (ce) begin
      if (awvalid && awready_ff) begin
        aw_got_ff <= 1'b1;
        awready_ff <= 1'b0;
        waddr_ff <= awaddr;
      end
      if (wvalid && wready_ff) begin
        w_got_ff <= 1'b1;
        wready_ff <= 1'b0;
        wdata_ff <= wdata;
        wstrb_ff <= wstrb;
      end
      if (wr_fire) begin
        bvalid_ff <= 1'b1;
        bresp_ff <= (wsel == 3'h0) ? rst_seq_pkg::RESP_SLVERR : rst_seq_pkg::RESP_OKAY;
      end
      if (bvalid_ff && bready) begin
        bvalid_ff <= 1'b0;
        aw_got_ff <= 1'b0;
        w_got_ff <= 1'b0;
        awready_ff <= 1'b1;
        wready_ff <= 1'b1;
      end
    end
  end

  // read channel, one outstanding read
  always_ff @(posedge clock) begin
    if (!rstn) begin
      arready_ff <= 1'b1;
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h00000000;
      rresp_ff <= rst_seq_pkg::RESP_OKAY;
    end else if (ce) begin
      if (arvalid && arready_ff) begin
        arready_ff <= 1'b0;
        rvalid_ff <= 1'b1;
        rresp_ff <= rst_seq_pkg::RESP_OKAY;
        case (reg_sel(araddr))
          3'h1: rdata_ff <= {24'h000000, status_ff};
          3'h2: rdata_ff <= {24'h000000, option_ff};
          3'h3: rdata_ff <= {30'h00000000, reset_cause_flags_ff};
          3'h4: rdata_ff <= {27'h0000000, cfg_ff};
          default: begin
            rdata_ff <= 32'h00000000;
            rresp_ff <= rst_seq_pkg::RESP_SLVERR;
          end
        endcase
      end else if (rvalid_ff && rready) begin
        rvalid_ff <= 1'b0;
        arready_ff <= 1'b1;
      end
    end
  end

  assign awready = awready_ff;
  assign wready = wready_ff;
  assign bvalid = bvalid_ff;
  assign bresp = bresp_ff;
  assign arready = arready_ff;
  assign rvalid = rvalid_ff;
  assign rdata = rdata_ff;
  assign rresp = rresp_ff;
  assign chip_reset = chip_reset_ff;
  assign sleeping = sleeping_ff;
  assign wake_resume = wake_resume_ff;

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);

  property p_delay_holds;
    ce && state_ff == rst_seq_pkg::ST_DELAY && !powerup_delay_timer_done |=> chip_reset_ff;
  endproperty
  a_delay_holds: assert property (p_delay_holds) else $error("reset released during delay");

  property p_delay_bound;
    state_ff == rst_seq_pkg::ST_DELAY |-> powerup_delay_timer_cnt_ff < rst_seq_pkg::POWERUP_DELAY_TIMER_LONG_TICKS;
  endproperty
  a_delay_bound: assert property (p_delay_bound) else $error("delay count past terminal");

  property p_delay_ends;
    ce && state_ff == rst_seq_pkg::ST_DELAY && powerup_delay_timer_done && !bor_trip
      |=> state_ff == rst_seq_pkg::ST_RUN;
  endproperty
  a_delay_ends: assert property (p_delay_ends) else $error("delay end missed");

  property p_wdt_off;
    ce && !cfg_ff.wdt_en |=> base_cnt_ff == 10'h000 && pre_cnt_ff == 8'h00;
  endproperty
  a_wdt_off: assert property (p_wdt_off) else $error("disabled watchdog counts");

  property p_bor_status;
    ce && bor_trip |=> status_ff[7:3] == 5'h03 && !reset_cause_flags_ff[rst_seq_pkg::BOR_BIT] && chip_reset_ff;
  endproperty
  a_bor_status: assert property (p_bor_status) else $error("brown-out effects wrong");

  property p_external_reset_pin_reset_cause_flags;
    ce && external_reset_pin_fall && !bor_trip && !wr_fire |=> $stable(reset_cause_flags_ff);
  endproperty
  a_external_reset_pin_reset_cause_flags: assert property (p_external_reset_pin_reset_cause_flags) else $error("pin reset changed flags");

  property p_wdt_wake;
    ce && wdt_wake && !bor_trip
      |=> state_ff == rst_seq_pkg::ST_RUN && status_ff[4:3] == 2'h0 ##1 1'b1;
  endproperty
  a_wdt_wake: assert property (p_wdt_wake) else $error("watchdog wake wrong");

  property p_wdt_reset_option;
    ce && wdt_reset |=> option_ff == rst_seq_pkg::OPTION_RST && !status_ff[rst_seq_pkg::TO_BIT];
  endproperty
  a_wdt_reset_option: assert property (p_wdt_reset_option) else $error("watchdog reset wrong");

  property p_bor_off;
    !cfg_ff.brownout_enable_field[1] |-> !bor_en;
  endproperty
  a_bor_off: assert property (p_bor_off) else $error("brown-out not disabled");

endmodule : rst_seq
`default_nettype wire

// ==== src/rst_seq_pkg.sv ====
// constants and types for the reset sequencer and watchdog
// assumes a 50 MHz system clock and a 31 kHz tick from the watchdog oscillator
package rst_seq_pkg;
  localparam int unsigned CLK_PERIOD_NS = 20;
  localparam int unsigned LFOSC_HZ = 31000;
  localparam int unsigned POWERUP_DELAY_TIMER_LONG_MS = 72;
  localparam int unsigned POWERUP_DELAY_TIMER_SHORT_MS = 64;
  localparam int unsigned WDT_BASE_MS = 17;
  // supply must stay low this long before it counts as a brown-out
  localparam int unsigned BOR_QUALIFY_NS = 100;

  localparam logic [11:0] POWERUP_DELAY_TIMER_LONG_TICKS = 12'(POWERUP_DELAY_TIMER_LONG_MS * LFOSC_HZ / 1000);
  localparam logic [11:0] POWERUP_DELAY_TIMER_SHORT_TICKS = 12'(POWERUP_DELAY_TIMER_SHORT_MS * LFOSC_HZ / 1000);
  localparam logic [9:0] WDT_BASE_TICKS = 10'(WDT_BASE_MS * LFOSC_HZ / 1000);
  localparam logic [7:0] BOR_QUALIFY_CYC = 8'((BOR_QUALIFY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  // register indices; byte address is four times the index
  localparam logic [11:0] STATUS_IDX = 12'h003;
  localparam logic [11:0] OPTION_IDX = 12'h081;
  localparam logic [11:0] RESET_CAUSE_FLAGS_IDX = 12'h08e;
  localparam logic [11:0] CFG_IDX = 12'h0c0;
  localparam logic [13:0] STATUS_ADDR = {STATUS_IDX, 2'b00};
  localparam logic [13:0] OPTION_ADDR = {OPTION_IDX, 2'b00};
  localparam logic [13:0] RESET_CAUSE_FLAGS_ADDR = {RESET_CAUSE_FLAGS_IDX, 2'b00};
  localparam logic [13:0] CFG_ADDR = {CFG_IDX, 2'b00};

  localparam int unsigned TO_BIT = 4;
  localparam int unsigned PD_BIT = 3;
  localparam int unsigned POR_BIT = 1;
  localparam int unsigned BOR_BIT = 0;
  localparam int unsigned PSA_BIT = 3;

  localparam logic [7:0] STATUS_RST = 8'h18;
  localparam logic [7:0] OPTION_RST = 8'hff;
  localparam logic [1:0] RESET_CAUSE_FLAGS_RST = 2'h0;
  localparam logic [4:0] CFG_RST = 5'h1f;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic powerup_delay_timer_disable;
    logic wdt_en;
    logic [1:0] brownout_enable_field;
    logic external_reset_pin_enable;
  } cfg_t;

  typedef enum logic [1:0] {
    ST_POWERON = 2'h0,
    ST_DELAY = 2'h1,
    ST_RUN = 2'h3,
    ST_SLEEP = 2'h2
  } seq_state_t;
endpackage : rst_seq_pkg

// ==== tb/testbench.sv ====
// self-checking bench for the reset sequencer over its register bus and event pins
// assumes rst_seq and rst_seq_pkg are compiled first; lfosc_tick is made here
`timescale 1ns/1ps
`default_nettype none
module testbench;
  typedef struct {logic [31:0] v; logic [31:0] m; logic [1:0] r;} exp_t;
  localparam logic [13:0] ST = rst_seq_pkg::STATUS_ADDR;
  localparam logic [13:0] OP = rst_seq_pkg::OPTION_ADDR;
  localparam logic [13:0] PC = rst_seq_pkg::RESET_CAUSE_FLAGS_ADDR;
  localparam logic [13:0] CF = rst_seq_pkg::CFG_ADDR;
  logic clock, rstn, ce, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, lfosc_tick, brownout_low, ext_reset_pin_n;
  logic sleep_instr, watchdog_clear_instr, irq_wake, chip_reset, sleeping, wake_resume;
  logic [13:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  logic [7:0] d, sv;
  exp_t rq[$];
  exp_t bq[$];
  exp_t e;
  int err_total, tests_run, hi, cyc, tick_div;
  integer seed;

  rst_seq DUT (.clock(clock), .rstn(rstn), .ce(ce),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
    .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready), .lfosc_tick(lfosc_tick), .brownout_low(brownout_low),
    .ext_reset_pin_n(ext_reset_pin_n), .sleep_instr(sleep_instr),
    .watchdog_clear_instr(watchdog_clear_instr), .irq_wake(irq_wake),
    .chip_reset(chip_reset), .sleeping(sleeping), .wake_resume(wake_resume));

  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end

  // slow oscillator stand-in: one tick every tick_div clocks keeps delays short
  always @(posedge clock) begin
    cyc <= cyc + 1;
    lfosc_tick <= (cyc % tick_div) == 0;
    if (cyc == 40000) begin
      err_total++;
      complete_run();
    end
  end

  // bus results are judged against the oldest note left by the driver
  always @(posedge clock) begin
    if (rvalid && rready) begin
      e = rq.pop_front();
      cmp(rdata & e.m, e.v);
      cmp({30'h0, rresp}, {30'h0, e.r});
    end
    if (bvalid && bready) begin
      e = bq.pop_front();
      cmp({30'h0, bresp}, {30'h0, e.r});
    end
  end

  task automatic cmp(input logic [31:0] got, input logic [31:0] want);
    tests_run++;
    if (got !== want) begin
      err_total++;
      $display("mismatch at %0t: got %h expected %h", $time, got, want);
    end
  endtask : cmp

  task automatic cmpn(input int got, input int lo, input int up);
    tests_run++;
    if (got < lo || got > up) begin
      err_total++;
      $display("mismatch at %0t: got %h expected %h..%h", $time, got, lo, up);
    end
  endtask : cmpn

  task automatic wr(input logic [13:0] a, input logic [7:0] v, input logic [3:0] s = 4'hf);
    logic aw;
    logic w;
    bq.push_back('{32'h0, 32'h0, rst_seq_pkg::RESP_OKAY});
    aw = 1'b0;
    w = 1'b0;
    awaddr <= a;
    wdata <= {24'($random(seed)), v};
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(aw && w)) begin
      @(posedge clock);
      if (!aw && awready) begin
        aw = 1'b1;
        awvalid <= 1'b0;
      end
      if (!w && wready) begin
        w = 1'b1;
        wvalid <= 1'b0;
      end
    end
    // bready stays up between writes so back-to-back calls never drive it twice in one step
    do @(posedge clock); while (!bvalid);
  endtask : wr

  task automatic rd(input logic [13:0] a, input logic [7:0] v, input logic [1:0] r = 2'h0);
    rq.push_back('{{24'h0, v}, 32'hffffffff, r});
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge clock); while (!arready);
    arvalid <= 1'b0;
    do @(posedge clock); while (!rvalid);
  endtask : rd

  // hi counts edges with chip_reset high over a fixed stretch
  task automatic tick(input int n);
    hi = 0;
    repeat (n) begin
      @(posedge clock);
      if (chip_reset !== 1'b0) hi++;
    end
  endtask : tick

  // hi counts edges until chip_reset shows the wanted level
  task automatic until_lvl(input logic lv);
    hi = 0;
    do begin
      @(posedge clock);
      hi++;
    end while (chip_reset !== lv);
  endtask : until_lvl

  task automatic bo(input int n);
    brownout_low <= 1'b1;
    tick(n);
    brownout_low <= 1'b0;
  endtask : bo

  task automatic pin(input int n);
    ext_reset_pin_n <= 1'b0;
    tick(n);
    ext_reset_pin_n <= 1'b1;
  endtask : pin

  task automatic slp();
    sleep_instr <= 1'b1;
    @(posedge clock);
    sleep_instr <= 1'b0;
    @(posedge clock);
    cmp({31'h0, sleeping}, 32'h1);
  endtask : slp

  task automatic wdclr();
    watchdog_clear_instr <= 1'b1;
    @(posedge clock);
    watchdog_clear_instr <= 1'b0;
  endtask : wdclr

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : complete_run

  initial begin
    seed = 32'he0beb720;
    {rstn, awvalid, wvalid, bready, arvalid, rready, brownout_low} = 7'h0;
    {sleep_instr, watchdog_clear_instr, irq_wake} = 3'h0;
    {ce, ext_reset_pin_n} = 2'h3;
    {awaddr, araddr, wdata, wstrb} = '0;
    {err_total, tests_run, cyc} = '0;
    tick_div = 1;
    repeat (6) @(posedge clock);
    rstn <= 1'b1;
    until_lvl(1'b0);
    cmpn(hi, 1, 4);
    rd(ST, 8'h18);
    rd(OP, 8'hff);
    rd(PC, 8'h00);
    rd(CF, 8'h1f);
    rd(14'h0010, 8'h00, rst_seq_pkg::RESP_SLVERR);
    d = $random(seed);
    wr(ST, d);
    sv = (d & 8'he7) | 8'h18;
    wr(ST, ~d, 4'h0);
    rd(ST, sv);
    wr(PC, 8'h03);
    rd(PC, 8'h03);
    wr(CF, 8'h10);
    wr(OP, 8'h00);
    pin(6);
    cmpn(hi, 0, 0);
    wr(CF, 8'h11);
    pin(6);
    cmpn(hi, 4, 6);
    until_lvl(1'b0);
    cmpn(hi, 1, 3);
    rd(ST, 8'h18 | (d & 8'h07));
    rd(OP, 8'hff);
    slp();
    rd(ST, 8'h10 | (d & 8'h07));
    irq_wake <= 1'b1;
    @(posedge clock);
    irq_wake <= 1'b0;
    @(posedge clock);
    cmp({31'h0, wake_resume}, 32'h1);
    @(posedge clock);
    cmp({31'h0, wake_resume | sleeping}, 32'h0);
    d = $random(seed) | 8'h80;
    wr(ST, d);
    slp();
    pin(6);
    until_lvl(1'b0);
    rd(ST, 8'h10 | (d & 8'h07));
    // watchdog at ratio 1, kept quiet by clears, then left to expire
    wr(OP, 8'h00);
    wr(CF, 8'h18);
    repeat (3) begin
      tick(400);
      cmpn(hi, 0, 0);
      wdclr();
    end
    until_lvl(1'b1);
    cmpn(hi, 524, 532);
    until_lvl(1'b0);
    rd(ST, 8'h08 | (d & 8'h07));
    rd(OP, 8'hff);
    wr(OP, 8'h09);
    wdclr();
    until_lvl(1'b1);
    cmpn(hi, 1051, 1060);
    until_lvl(1'b0);
    wr(OP, 8'h00);
    wdclr();
    slp();
    hi = 0;
    do begin
      @(posedge clock);
      hi++;
    end while (wake_resume !== 1'b1 && hi < 700);
    cmpn(hi, 518, 532);
    rd(ST, d & 8'h07);
    rd(OP, 8'h00);
    wr(CF, 8'h10);
    // every brown-out enable code with the delay disabled
    wr(PC, 8'h03);
    for (int c = 0; c < 4; c++) begin
      wr(CF, 8'h10 | 8'(c << 1));
      bo(8);
      cmpn(hi, c[1] ? 2 : 0, c[1] ? 8 : 0);
      until_lvl(1'b0);
    end
    rd(PC, 8'h02);
    rd(ST, 8'h18);
    bo(3);
    cmpn(hi, 0, 0);
    wr(CF, 8'h14);
    slp();
    bo(8);
    cmpn(hi, 0, 0);
    irq_wake <= 1'b1;
    @(posedge clock);
    irq_wake <= 1'b0;
    // full power-up delay, then a brown-out inside it at half tick rate
    wr(CF, 8'h06);
    bo(8);
    until_lvl(1'b0);
    cmpn(hi, 2232, 2245);
    bo(8);
    tick(200);
    bo(8);
    tick_div = 2;
    until_lvl(1'b0);
    cmpn(hi, 3966, 3992);
    // with the enable low a qualified brown-out must not reach the reset output
    ce <= 1'b0;
    bo(8);
    ce <= 1'b1;
    cmpn(hi, 0, 0);
    rd(ST, 8'h18);
    complete_run();
  end
endmodule : testbench
`default_nettype wire
